// [dv/dhpp_host_model.sv]
// host side bus arbiter model: grants the bus and stretches transfers with wait
`timescale 1ns/1ps
`default_nettype none
module dhpp_host_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // request from the device
  input wire logic busRequestOe,
  // grant and wait toward the device
  output logic grantN,
  output logic waitN
);
  logic slow_reg;
  logic [3:0] cnt_reg;

  // alternate prompt and slow answers so both paths of the device get used
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_reg <= 4'h0;
      slow_reg <= 1'b0;
    end
    else if (!busRequestOe)
    begin
      cnt_reg <= 4'h0;
      if (cnt_reg != 4'h0)
        slow_reg <= !slow_reg;
    end
    else if (cnt_reg != 4'hF)
      cnt_reg <= cnt_reg + 4'h1;
  end

  // grant only while a request stands; released as soon as it drops
  assign grantN = !(busRequestOe && cnt_reg >= (slow_reg ? 4'h6 : 4'h1));
  // slow answer also stalls the byte through the wait line
  assign waitN = !(slow_reg && cnt_reg >= 4'h7 && cnt_reg < 4'hC);
endmodule
`default_nettype wire

// [dv/test_dma_host_programming_port.sv]
// self-checking bench of the dma host programming port
`timescale 1ns/1ps
`default_nettype none
module test_dma_host_programming_port;
  logic clk;
  logic rst;
  logic csN;
  logic ioReq_n;
  logic rd_n;
  logic wr_n;
  logic ready;
  logic [7:0] dataIn;
  logic [7:0] dataOut;
  logic dataOe;
  logic bus_grant_in_n;
  logic busRequestOe;
  logic transferStrobe;
  logic reqPinN;
  logic waitN;
  logic [31:0] lfsr = 32'hD8A2325D;
  logic [31:0] r;
  logic [15:0] aStart;
  logic [15:0] len;
  logic [15:0] bAddr;
  logic [7:0] cfg [3] = '{8'h20, 8'h10, 8'h40};
  int miscompares = 0;
  int comparisons = 0;
  int strobes = 0;
  int i;

  dhpp_port i_dut (.clk(clk), .rst(rst), .selWait_n(csN & waitN), .ioReq_n(ioReq_n),
    .rd_n(rd_n), .wr_n(wr_n), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
    .ready(ready), .bus_grant_in_n(bus_grant_in_n), .bus_request_out_n(reqPinN),
    .busRequestOe(busRequestOe), .transferStrobe(transferStrobe));
  dhpp_host_model i_host (.clk(clk), .rst(rst), .busRequestOe(busRequestOe),
    .grantN(bus_grant_in_n), .waitN(waitN));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = !clk;
  end

  always @(posedge clk)
    if (transferStrobe === 1'b1)
      strobes++;

  function logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  // expected status byte; interrupt and match flags never pend here
  function logic [7:0] stat(logic xfer, logic rdy, logic eob);
    return {2'b00, !eob, 1'b1, 1'b1, 1'b0, !rdy, xfer};
  endfunction

  task automatic test_done();
    $display("checks %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wrByte(logic [7:0] d);
    dataIn = d;
    cyc(1);
    {csN, ioReq_n, wr_n} = 3'b000;
    cyc(7);
    {csN, ioReq_n, wr_n} = 3'b111;
    cyc(7);
  endtask

  task automatic rdByte(string name, logic [7:0] exp);
    {csN, ioReq_n, rd_n} = 3'b000;
    cyc(7);
    chk("read enable", 16'h1, {15'h0, dataOe});
    chk(name, {8'h00, exp}, {8'h00, dataOut});
    {csN, ioReq_n, rd_n} = 3'b111;
    cyc(8);
    chk("read enable off", 16'h0, {15'h0, dataOe});
  endtask

  task automatic readAll(logic [7:0] st, logic [15:0] cnt, logic [15:0] a, logic [15:0] b);
    rdByte("status", st);
    rdByte("count low", cnt[7:0]);
    rdByte("count high", cnt[15:8]);
    rdByte("first addr low", a[7:0]);
    rdByte("first addr high", a[15:8]);
    rdByte("second addr low", b[7:0]);
    rdByte("second addr high", b[15:8]);
  endtask

  initial
  begin
    repeat (100000) @(posedge clk);
    miscompares++;
    test_done();
  end

  initial
  begin
    {csN, ioReq_n, rd_n, wr_n} = 4'hF;
    dataIn = 8'h00;
    ready = 1'b0;
    rst = 1'b1;
    bAddr = 16'h0000;
    cyc(3);
    rst = 1'b0;
    cyc(4);
    readAll(stat(0, 0, 0), 16'h0, 16'h0, 16'h0);
    rdByte("status again", stat(0, 0, 0));
    ready = 1'b1;
    cyc(20);
    chk("request while disabled", 16'h0, {15'h0, busRequestOe});
    ready = 1'b0;
    wrByte(8'h87);
    wrByte(8'h83);
    ready = 1'b1;
    cyc(20);
    chk("request after disable", 16'h0, {15'h0, busRequestOe});
    for (int m = 0; m < 3; m++)
    begin
      wrByte(8'hC3);
      wrByte(cfg[m]);
      // a timing byte that looks like enable must be swallowed as data
      if (cfg[m][6])
        wrByte(8'h87);
      r = rnd();
      // full group first, then a base that skips the high bytes
      if (m == 0)
      begin
        aStart = r[15:0];
        len = {14'h0, r[17:16]} + 16'h1;
        wrByte(8'h79);
        wrByte(aStart[7:0]);
        wrByte(aStart[15:8]);
        wrByte(len[7:0]);
        wrByte(len[15:8]);
      end
      else
      begin
        aStart[7:0] = r[7:0];
        len = {14'h0, r[9:8]} + 16'h1;
        wrByte(8'h29);
        wrByte(aStart[7:0]);
        wrByte(len[7:0]);
      end
      wrByte(8'hCF);
      readAll(stat(0, 1, 0), 16'h0, aStart, bAddr);
      strobes = 0;
      wrByte(8'h87);
      for (i = 0; i < 600 && strobes < int'(len); i++)
        cyc(1);
      if (strobes < int'(len))
      begin
        miscompares++;
        $display("mismatch transfer count expected %0d seen %0d", len, strobes);
        test_done();
      end
      cyc(20);
      chk("bytes moved", len, 16'(strobes));
      chk("request after end", 16'h0, {15'h0, busRequestOe});
      chk("request pin level", 16'h0, {15'h0, reqPinN});
      if (m == 1)
        bAddr = bAddr + len;
      else if (m == 2)
        bAddr = bAddr - len;
      readAll(stat(1, 1, 1), len, aStart + len, bAddr);
    end
    // leave a group sequence open so the reset has something to cancel
    wrByte(8'h79);
    rdByte("status mid", stat(1, 1, 1));
    rst = 1'b1;
    cyc(4);
    rst = 1'b0;
    cyc(6);
    readAll(stat(0, 1, 0), 16'h0, 16'h0, 16'h0);
    // these bytes would be eaten as data if the cut sequence survived
    r = rnd();
    wrByte(8'h29);
    wrByte({r[7:1], 1'b1});
    wrByte(8'h00);
    wrByte(8'hCF);
    readAll(stat(0, 1, 0), 16'h0, {8'h00, r[7:1], 1'b1}, 16'h0);
    test_done();
  end
endmodule
`default_nettype wire

// [inc/dhpp_defs.svh]
// constants of the dma host programming port: offsets, fields, reset values
`ifndef DHPP_DEFS_SVH
`define DHPP_DEFS_SVH

// read sequence positions
`define DHPP_RD_STATUS 3'h0
`define DHPP_RD_COUNT_LO 3'h1
`define DHPP_RD_COUNT_HI 3'h2
`define DHPP_RD_A_LO 3'h3
`define DHPP_RD_A_HI 3'h4
`define DHPP_RD_B_LO 3'h5
`define DHPP_RD_B_HI 3'h6
`define DHPP_RD_LAST 3'h6

// status byte bit positions
`define DHPP_ST_XFER 0
`define DHPP_ST_READY_N 1
`define DHPP_ST_INT_N 3
`define DHPP_ST_MATCH_N 4
`define DHPP_ST_EOB_N 5

// base byte decode
`define DHPP_BASE_CMD_BIT 7
`define DHPP_BASE_PTR_LSB 3
`define DHPP_BASE_PTR_MSB 6
`define DHPP_PORTB_FIXED_BIT 5
`define DHPP_PORTB_INC_BIT 4
`define DHPP_PORTB_PTR_BIT 6

// command codes
`define DHPP_CMD_ENABLE 8'h87
`define DHPP_CMD_DISABLE 8'h83
`define DHPP_CMD_RESET 8'hC3
`define DHPP_CMD_LOAD 8'hCF

// reset values
`define DHPP_WORD_RST 16'h0000
`define DHPP_BYTE_RST 8'h00
`define DHPP_PTR_RST 4'h0

`endif

// [inc/dhpp_pkg.sv]
// types of the dma host programming port
`default_nettype none
package dhpp_pkg;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_REQ = 2'b01,
    BUS_XFER = 2'b10,
    BUS_REL = 2'b11
  } dhpp_bus_state_t;

  typedef enum logic [1:0] {
    SEQ_BASE = 2'b00,
    SEQ_XFER_BYTES = 2'b01,
    SEQ_CFG_BYTE = 2'b10
  } dhpp_wseq_t;

endpackage
`default_nettype wire

// [verilog/dhpp_port.sv]
// host programming port and bus request logic of a two-port byte dma
`timescale 1ns/1ps
`default_nettype none
`include "dhpp_defs.svh"

// Operation
// - enabled and disabled states; only enabled may take the bus and move bytes
// - while disabled no new bus request; a request standing at disable drops a cycle later or finishes its transfer
// - any reset leaves the device disabled without a command
// - host input cycles on the port each return the next readable byte
// - reads run status first through second port address high, seven bytes
// - readable bytes show status and counters as evolved since last reset
// - status holds transfer-occurred and active-low ready, interrupt, match, end flags
// - after status: count low, high, first port low, high, second low, high
// - host writes a group base byte first; its code selects the group
// - base pointer bits select following bytes, taken in order, unselected skipped
// - second port address fixed or varying; varying 1 counts up, 0 down
// - select/wait pin is chip select as slave, wait input as bus master
// - enabled with ready active and bus free, request on next edge
module dhpp_port (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // host i/o cycle pins
  input wire logic selWait_n,
  input wire logic ioReq_n,
  input wire logic rd_n,
  input wire logic wr_n,
  // data bus pin split in three
  input wire logic [7:0] dataIn,
  output logic [7:0] dataOut,
  output logic dataOe,
  // bus handshake
  input wire logic ready,
  input wire logic bus_grant_in_n,
  output logic bus_request_out_n,
  output logic busRequestOe,
  // one pulse per byte moved
  output logic transferStrobe
);

  logic [3:0] strobeSync;
  logic [7:0] dataSync;
  logic grantSync;
  logic readySync;
  logic ceSync;
  logic ioSync;
  logic rdSync;
  logic wrSync;

  dhpp_sync #(.WIDTH(4), .INIT(4'hF)) uStrobeSync (
    .clk(clk),
    .rst(rst),
    .pinIn({selWait_n, ioReq_n, rd_n, wr_n}),
    .levelOut(strobeSync)
  );

  dhpp_sync #(.WIDTH(8), .INIT(8'h00)) uDataSync (
    .clk(clk),
    .rst(rst),
    .pinIn(dataIn),
    .levelOut(dataSync)
  );

  dhpp_sync #(.WIDTH(2), .INIT(2'h2)) uHandSync (
    .clk(clk),
    .rst(rst),
    .pinIn({bus_grant_in_n, ready}),
    .levelOut({grantSync, readySync})
  );

  assign ceSync = strobeSync[3];
  assign ioSync = strobeSync[2];
  assign rdSync = strobeSync[1];
  assign wrSync = strobeSync[0];

  dhpp_pkg::dhpp_bus_state_t busState_reg;
  dhpp_pkg::dhpp_wseq_t seqState_reg;
  logic enable_reg;
  logic grantSeen_reg;
  logic [2:0] rdPtr_reg;
  logic [3:0] pend_reg;
  logic hostRdPrev_reg;
  logic hostWrPrev_reg;
  logic [7:0] dataOut_reg;
  logic dataOe_reg;
  logic strobe_reg;
  logic [15:0] portABase_reg;
  logic [15:0] blockLen_reg;
  logic portBFixed_reg;
  logic portBInc_reg;
  logic [15:0] byteCount_reg;
  logic [15:0] portAAddr_reg;
  logic [15:0] portBAddr_reg;
  logic xferFlag_reg;
  logic eobFlag_reg;

  logic ownBus;
  logic hostRd;
  logic hostWr;
  logic rdStart;
  logic rdEnd;
  logic wrStart;
  logic isXferBase;
  logic isPortBCfg;
  logic isCmd;
  logic cmdEnable;
  logic cmdDisable;
  logic cmdReset;
  logic cmdLoad;
  logic xferDone;
  logic lastByte;
  logic [7:0] statusByte;
  logic [7:0] readByte;
  logic [3:0] pickBit;

  // as master the select pin is a wait line, so host cycles are not decoded
  assign ownBus = (busState_reg == dhpp_pkg::BUS_XFER);
  assign hostRd = !ceSync && !ioSync && !rdSync && !ownBus;
  assign hostWr = !ceSync && !ioSync && !wrSync && !ownBus;
  assign rdStart = hostRd && !hostRdPrev_reg;
  assign rdEnd = !hostRd && hostRdPrev_reg;
  assign wrStart = hostWr && !hostWrPrev_reg;

  // group decode of a base byte
  assign isXferBase = !dataSync[`DHPP_BASE_CMD_BIT] && (dataSync[1:0] != 2'h0);
  assign isPortBCfg = !dataSync[`DHPP_BASE_CMD_BIT] && (dataSync[2:0] == 3'h0);
  assign isCmd = dataSync[`DHPP_BASE_CMD_BIT] && (dataSync[1:0] == 2'h3);
  assign cmdEnable = wrStart && (seqState_reg == dhpp_pkg::SEQ_BASE) && isCmd
                     && (dataSync == `DHPP_CMD_ENABLE);
  assign cmdDisable = wrStart && (seqState_reg == dhpp_pkg::SEQ_BASE) && isCmd
                      && (dataSync == `DHPP_CMD_DISABLE);
  assign cmdReset = wrStart && (seqState_reg == dhpp_pkg::SEQ_BASE) && isCmd
                    && (dataSync == `DHPP_CMD_RESET);
  assign cmdLoad = wrStart && (seqState_reg == dhpp_pkg::SEQ_BASE) && isCmd
                   && (dataSync == `DHPP_CMD_LOAD);

  // wait low stretches the byte operation
  assign xferDone = (busState_reg == dhpp_pkg::BUS_XFER) && ceSync;
  assign lastByte = (byteCount_reg + 16'h0001) == blockLen_reg;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      hostRdPrev_reg <= 1'b0;
      hostWrPrev_reg <= 1'b0;
    end
    else
    begin
      hostRdPrev_reg <= hostRd;
      hostWrPrev_reg <= hostWr;
    end
  end

  // enable state; a host command and end of block never meet, the host is off the bus
  always_ff @(posedge clk)
  begin
    if (rst)
      enable_reg <= 1'b0;
    else if (cmdReset || cmdDisable || (xferDone && lastByte))
      enable_reg <= 1'b0;
    else if (cmdEnable)
      enable_reg <= 1'b1;
  end

  // bus request state machine
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      busState_reg <= dhpp_pkg::BUS_IDLE;
      grantSeen_reg <= 1'b0;
    end
    else
    begin
      case (busState_reg)
        dhpp_pkg::BUS_IDLE:
        begin
          grantSeen_reg <= 1'b0;
          if (enable_reg && readySync && grantSync)
            busState_reg <= dhpp_pkg::BUS_REQ;
        end
        dhpp_pkg::BUS_REQ:
        begin
          grantSeen_reg <= !grantSync;
          if (!enable_reg)
            busState_reg <= dhpp_pkg::BUS_IDLE;
          else if (grantSeen_reg && !grantSync)
            busState_reg <= dhpp_pkg::BUS_XFER;
        end
        dhpp_pkg::BUS_XFER:
        begin
          if (xferDone)
            busState_reg <= dhpp_pkg::BUS_REL;
        end
        dhpp_pkg::BUS_REL:
        begin
          // the next request waits for the grant to be withdrawn
          if (grantSync)
            busState_reg <= dhpp_pkg::BUS_IDLE;
        end
        default:
          busState_reg <= dhpp_pkg::BUS_IDLE;
      endcase
    end
  end

  // byte counter, address counters and status flags
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      byteCount_reg <= `DHPP_WORD_RST;
      portAAddr_reg <= `DHPP_WORD_RST;
      portBAddr_reg <= `DHPP_WORD_RST;
      xferFlag_reg <= 1'b0;
      eobFlag_reg <= 1'b0;
      strobe_reg <= 1'b0;
    end
    else
    begin
      strobe_reg <= xferDone;
      if (xferDone)
      begin
        byteCount_reg <= byteCount_reg + 16'h0001;
        portAAddr_reg <= portAAddr_reg + 16'h0001;
        if (!portBFixed_reg)
          portBAddr_reg <= portBInc_reg ? portBAddr_reg + 16'h0001
                                        : portBAddr_reg - 16'h0001;
      end
      else if (cmdLoad)
      begin
        byteCount_reg <= `DHPP_WORD_RST;
        portAAddr_reg <= portABase_reg;
      end
      // a transfer in the clearing cycle keeps its flags
      if (xferDone)
        xferFlag_reg <= 1'b1;
      else if (cmdLoad || cmdReset)
        xferFlag_reg <= 1'b0;
      if (xferDone && lastByte)
        eobFlag_reg <= 1'b1;
      else if (cmdLoad || cmdReset)
        eobFlag_reg <= 1'b0;
    end
  end

  // lowest selected associated byte is next
  always_comb
  begin
    pickBit = 4'h0;
    if (pend_reg[0])
      pickBit = 4'h1;
    else if (pend_reg[1])
      pickBit = 4'h2;
    else if (pend_reg[2])
      pickBit = 4'h4;
    else if (pend_reg[3])
      pickBit = 4'h8;
  end

  // write group sequencer
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      seqState_reg <= dhpp_pkg::SEQ_BASE;
      pend_reg <= `DHPP_PTR_RST;
      portABase_reg <= `DHPP_WORD_RST;
      blockLen_reg <= `DHPP_WORD_RST;
      portBFixed_reg <= 1'b0;
      portBInc_reg <= 1'b0;
    end
    else if (wrStart)
    begin
      case (seqState_reg)
        dhpp_pkg::SEQ_BASE:
        begin
          if (isXferBase)
          begin
            pend_reg <= dataSync[`DHPP_BASE_PTR_MSB:`DHPP_BASE_PTR_LSB];
            if (dataSync[`DHPP_BASE_PTR_MSB:`DHPP_BASE_PTR_LSB] != 4'h0)
              seqState_reg <= dhpp_pkg::SEQ_XFER_BYTES;
          end
          else if (isPortBCfg)
          begin
            portBFixed_reg <= dataSync[`DHPP_PORTB_FIXED_BIT];
            portBInc_reg <= dataSync[`DHPP_PORTB_INC_BIT];
            pend_reg <= {3'h0, dataSync[`DHPP_PORTB_PTR_BIT]};
            if (dataSync[`DHPP_PORTB_PTR_BIT])
              seqState_reg <= dhpp_pkg::SEQ_CFG_BYTE;
          end
        end
        dhpp_pkg::SEQ_XFER_BYTES:
        begin
          if (pickBit[0])
            portABase_reg[7:0] <= dataSync;
          if (pickBit[1])
            portABase_reg[15:8] <= dataSync;
          if (pickBit[2])
            blockLen_reg[7:0] <= dataSync;
          if (pickBit[3])
            blockLen_reg[15:8] <= dataSync;
          pend_reg <= pend_reg & ~pickBit;
          if ((pend_reg & ~pickBit) == 4'h0)
            seqState_reg <= dhpp_pkg::SEQ_BASE;
        end
        dhpp_pkg::SEQ_CFG_BYTE:
        begin
          // the cycle timing byte is taken and not used by this port
          pend_reg <= `DHPP_PTR_RST;
          seqState_reg <= dhpp_pkg::SEQ_BASE;
        end
        default:
          seqState_reg <= dhpp_pkg::SEQ_BASE;
      endcase
    end
  end

  always_comb
  begin
    statusByte = 8'h00;
    statusByte[`DHPP_ST_XFER] = xferFlag_reg;
    statusByte[`DHPP_ST_READY_N] = !readySync;
    statusByte[`DHPP_ST_INT_N] = 1'b1;
    statusByte[`DHPP_ST_MATCH_N] = 1'b1;
    statusByte[`DHPP_ST_EOB_N] = !eobFlag_reg;
  end

  always_comb
  begin
    case (rdPtr_reg)
      `DHPP_RD_STATUS: readByte = statusByte;
      `DHPP_RD_COUNT_LO: readByte = byteCount_reg[7:0];
      `DHPP_RD_COUNT_HI: readByte = byteCount_reg[15:8];
      `DHPP_RD_A_LO: readByte = portAAddr_reg[7:0];
      `DHPP_RD_A_HI: readByte = portAAddr_reg[15:8];
      `DHPP_RD_B_LO: readByte = portBAddr_reg[7:0];
      `DHPP_RD_B_HI: readByte = portBAddr_reg[15:8];
      default: readByte = `DHPP_BYTE_RST;
    endcase
  end

  // read sequence pointer
  always_ff @(posedge clk)
  begin
    if (rst || cmdReset)
      rdPtr_reg <= `DHPP_RD_STATUS;
    else if (rdEnd)
    begin
      if (rdPtr_reg == `DHPP_RD_LAST)
        rdPtr_reg <= `DHPP_RD_STATUS;
      else
        rdPtr_reg <= rdPtr_reg + 3'h1;
    end
  end

  // byte is frozen at the start of the cycle so it cannot change under the host
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dataOut_reg <= `DHPP_BYTE_RST;
      dataOe_reg <= 1'b0;
    end
    else
    begin
      if (rdStart)
        dataOut_reg <= readByte;
      dataOe_reg <= hostRd;
    end
  end

  assign dataOut = dataOut_reg;
  assign dataOe = dataOe_reg;
  assign bus_request_out_n = 1'b0;
  assign busRequestOe = (busState_reg == dhpp_pkg::BUS_REQ)
                        || (busState_reg == dhpp_pkg::BUS_XFER);
  assign transferStrobe = strobe_reg;

  chk_disabled_noreq: assert property (@(posedge clk) disable iff (rst)
    (busState_reg == dhpp_pkg::BUS_IDLE && !enable_reg) |=> !busRequestOe)
    else $error("request raised while disabled");

  chk_reset_state: assert property (@(posedge clk)
    rst |=> (!enable_reg && rdPtr_reg == 3'h0 && !busRequestOe))
    else $error("reset did not leave device disabled");

  chk_reset_seq: assert property (@(posedge clk)
    rst |=> (seqState_reg == dhpp_pkg::SEQ_BASE && pend_reg == 4'h0))
    else $error("reset kept a write sequence");

  chk_req_follows: assert property (@(posedge clk) disable iff (rst)
    (busState_reg == dhpp_pkg::BUS_IDLE && enable_reg && readySync && grantSync)
    |=> busRequestOe)
    else $error("no request after ready");

  chk_grant_twice: assert property (@(posedge clk) disable iff (rst)
    $rose(busState_reg == dhpp_pkg::BUS_XFER) |-> ($past(!grantSync, 1) && $past(!grantSync, 2)))
    else $error("transfer started without two low grant samples");

  chk_read_step: assert property (@(posedge clk) disable iff (rst)
    (rdEnd && !cmdReset && rdPtr_reg != 3'h6) |=> rdPtr_reg == $past(rdPtr_reg) + 3'h1)
    else $error("read pointer did not step");

  chk_read_wrap: assert property (@(posedge clk) disable iff (rst)
    (rdEnd && rdPtr_reg == 3'h6) |=> rdPtr_reg == 3'h0)
    else $error("read pointer did not wrap");

  chk_status_read: assert property (@(posedge clk) disable iff (rst)
    (rdStart && rdPtr_reg == 3'h0) |=>
    (dataOut[0] == $past(xferFlag_reg) && dataOut[1] == !$past(readySync)
     && dataOut[5] == !$past(eobFlag_reg)))
    else $error("status byte wrong");

  chk_wait_stall: assert property (@(posedge clk) disable iff (rst)
    (busState_reg == dhpp_pkg::BUS_XFER && !ceSync) |=>
    (busState_reg == dhpp_pkg::BUS_XFER && $stable(byteCount_reg)))
    else $error("wait did not stall transfer");

  chk_portb_step: assert property (@(posedge clk) disable iff (rst)
    xferDone |=> (portBAddr_reg == ($past(portBFixed_reg) ? $past(portBAddr_reg)
                  : $past(portBInc_reg) ? $past(portBAddr_reg) + 16'h0001
                  : $past(portBAddr_reg) - 16'h0001)))
    else $error("second port address step wrong");

  chk_count_step: assert property (@(posedge clk) disable iff (rst)
    xferDone |=> (byteCount_reg == $past(byteCount_reg) + 16'h0001 && xferFlag_reg))
    else $error("byte counter did not advance");

endmodule
`default_nettype wire

// [verilog/dhpp_sync.sv]
// three-flop pin synchroniser; a change counts once the last two flops agree
`timescale 1ns/1ps
`default_nettype none
module dhpp_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pin and filtered level
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] levelOut
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] level_reg;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
    end
    else
    begin
      s1_reg <= pinIn;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // per bit, so a bus holds each bit until it has settled
  always_ff @(posedge clk)
  begin
    if (rst)
      level_reg <= INIT;
    else
      for (int i = 0; i < WIDTH; i++)
        if (s2_reg[i] == s3_reg[i])
          level_reg[i] <= s3_reg[i];
  end

  assign levelOut = level_reg;

endmodule
`default_nettype wire
